/* File: rtl/sppio_pkg.sv */
// shared constants and types of the six-port parallel I/O bank
package sppio_pkg;

    // ------------------------------------------------------------
    // bus and port geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int NUM_PORTS = 6;

    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int PORT_C = 2;
    localparam int PORT_D = 3;
    localparam int PORT_E = 4;
    localparam int PORT_F = 5;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] PORT_A_DATA_OFF = 4'h0;
    localparam logic [3:0] PORT_B_DATA_OFF = 4'h1;
    localparam logic [3:0] PORT_C_DATA_OFF = 4'h2;
    localparam logic [3:0] PORT_D_DATA_OFF = 4'h3;
    localparam logic [3:0] PORT_A_DIR_OFF = 4'h4;
    localparam logic [3:0] PORT_B_DIR_OFF = 4'h5;
    localparam logic [3:0] PORT_C_DIR_OFF = 4'h6;
    localparam logic [3:0] PORT_D_DIR_OFF = 4'h7;
    localparam logic [3:0] PORT_E_DATA_OFF = 4'h8;
    localparam logic [3:0] PORT_F_DATA_OFF = 4'h9;
    localparam logic [3:0] PORT_E_DIR_OFF = 4'hC;
    localparam logic [3:0] PORT_F_DIR_OFF = 4'hD;

    localparam logic [5:0][3:0] DATA_OFF = {PORT_F_DATA_OFF, PORT_E_DATA_OFF, PORT_D_DATA_OFF,
                                            PORT_C_DATA_OFF, PORT_B_DATA_OFF, PORT_A_DATA_OFF};
    localparam logic [5:0][3:0] DIR_OFF = {PORT_F_DIR_OFF, PORT_E_DIR_OFF, PORT_D_DIR_OFF,
                                           PORT_C_DIR_OFF, PORT_B_DIR_OFF, PORT_A_DIR_OFF};

    // ------------------------------------------------------------
    // implemented bits and reset values
    // ------------------------------------------------------------
    localparam logic [5:0][7:0] DATA_MASK = {8'h0F, 8'hFF, 8'h7F, 8'h1F, 8'hFF, 8'hFF};
    localparam logic [5:0][7:0] DIR_MASK = {8'h0F, 8'hFF, 8'h7F, 8'h9F, 8'hFF, 8'hFF};
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] READ_NONE = 8'h00;
    localparam int BUSCLK_PIN = 2;
    localparam int BUSCLK_EN_BIT = 7;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sppio_req_s;

    typedef struct packed {
        logic [5:0][7:0] out;
        logic [5:0][7:0] oe;
    } sppio_pins_s;

endpackage

/* File: rtl/sppio_port.sv */
// one parallel port: data latches, direction bits, input synchroniser, read select
`timescale 1ns/1ps
`default_nettype none
module sppio_port #(
    parameter logic [7:0] DATA_MASK = 8'hFF,
    parameter logic [7:0] DIR_MASK = 8'hFF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_data,
    input wire logic wr_dir,
    input wire logic [7:0] wdata,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] claim,
    output logic [7:0] latch,
    output logic [7:0] oe,
    output logic [7:0] data_read,
    output logic [7:0] dir_read
);
    import sppio_pkg::*;

    logic [7:0] latch_reg;
    logic [7:0] dir_reg;
    logic [7:0] meta_reg;
    logic [7:0] sync_reg;

    // ------------------------------------------------------------
    // latches keep their value through reset
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (wr_data) begin
            latch_reg <= wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dir_reg <= DIR_RESET;
        end else if (wr_dir) begin
            dir_reg <= wdata & DIR_MASK;
        end
    end

    // two-stage chain for pin levels
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= READ_NONE;
            sync_reg <= READ_NONE;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
        end
    end

    // ------------------------------------------------------------
    // pin drive and read select
    // ------------------------------------------------------------
    assign latch = latch_reg & DATA_MASK;
    assign oe = dir_reg & ~claim & DATA_MASK;
    assign data_read = ((dir_reg & latch) | (~dir_reg & ~claim & sync_reg)) & DATA_MASK;
    assign dir_read = dir_reg;
endmodule
`default_nettype wire

/* File: rtl/sppio_busclk.sv */
// bus clock image driven out on a port pin
`timescale 1ns/1ps
`default_nettype none
module sppio_busclk (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    output logic busclk_out
);
    import sppio_pkg::*;

    logic toggle_reg;

    // toggles every cycle while enabled, parks low otherwise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            toggle_reg <= 1'b0;
        end else if (enable) begin
            toggle_reg <= ~toggle_reg;
        end else begin
            toggle_reg <= 1'b0;
        end
    end

    assign busclk_out = toggle_reg;
endmodule
`default_nettype wire

/* File: rtl/sppio_bank.sv */
// six-port parallel I/O bank with register port
// ------------------------------------------------------------
// Summary of operation
// - port A: eight pins, eight latches
// - each pin has a read/write latch
// - reset leaves data latches unchanged
// - direction one drives pin, zero floats
// - reset clears port A direction bits
// - output pin reads back its latch
// - input pin reads sampled pin level
// - data writes always update latches
// - write to input pin leaves pin alone
// - port B: eight latches, eight direction bits
// - port C data bits seven..five read zero
// - port C direction: clock enable, bits 4..0
// - port D data bit seven reads zero
// - port D direction bit seven reads zero
// - port E: eight latches, eight direction bits
// - port F data bits seven..four read zero
// - clock enable drives bus clock on C2
// - claimed B pin reads zero when input
// ------------------------------------------------------------
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module sppio_bank (
    input wire logic clk,
    input wire logic rst,
    input wire sppio_pkg::sppio_req_s bus,
    input wire logic [5:0][7:0] pin_in,
    input wire logic [7:0] adc_claim_b,
    output logic [7:0] rdata,
    output sppio_pkg::sppio_pins_s pins
);
    import sppio_pkg::*;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
        hit = (addr == off);
    endfunction

    logic [5:0] wr_data_sel;
    logic [5:0] wr_dir_sel;
    logic [5:0] rd_data_sel;
    logic [5:0] rd_dir_sel;
    logic [5:0][7:0] claim_w;
    logic [5:0][7:0] latch_w;
    logic [5:0][7:0] oe_w;
    logic [5:0][7:0] data_read_w;
    logic [5:0][7:0] dir_read_w;
    logic [5:0][7:0] pin_out_w;
    logic [5:0][7:0] pin_oe_w;
    logic [7:0] read_mux;
    logic [7:0] rdata_reg;
    logic busclk_en;
    logic busclk_w;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
            assign wr_data_sel[gi] = bus.wr && hit(bus.addr, DATA_OFF[gi]);
            assign wr_dir_sel[gi] = bus.wr && hit(bus.addr, DIR_OFF[gi]);
            assign rd_data_sel[gi] = bus.rd && hit(bus.addr, DATA_OFF[gi]);
            assign rd_dir_sel[gi] = bus.rd && hit(bus.addr, DIR_OFF[gi]);
            assign claim_w[gi] = (gi == PORT_B) ? adc_claim_b : READ_NONE;

            // ------------------------------------------------------------
            // one port
            // ------------------------------------------------------------
            sppio_port #(
                .DATA_MASK(DATA_MASK[gi]),
                .DIR_MASK(DIR_MASK[gi])
            ) u_port (
                .clk(clk),
                .rst(rst),
                .wr_data(wr_data_sel[gi]),
                .wr_dir(wr_dir_sel[gi]),
                .wdata(bus.wdata),
                .pin_in(pin_in[gi]),
                .claim(claim_w[gi]),
                .latch(latch_w[gi]),
                .oe(oe_w[gi]),
                .data_read(data_read_w[gi]),
                .dir_read(dir_read_w[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // bus clock on port C pin 2
    // ------------------------------------------------------------
    assign busclk_en = dir_read_w[PORT_C][BUSCLK_EN_BIT];

    sppio_busclk u_busclk (
        .clk(clk),
        .rst(rst),
        .enable(busclk_en),
        .busclk_out(busclk_w)
    );

    always_comb begin
        pin_out_w = latch_w;
        pin_oe_w = oe_w;
        if (busclk_en) begin
            pin_out_w[PORT_C][BUSCLK_PIN] = busclk_w;
            pin_oe_w[PORT_C][BUSCLK_PIN] = 1'b1;
        end
    end

    assign pins = '{out: pin_out_w, oe: pin_oe_w};

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    always_comb begin
        read_mux = READ_NONE;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (rd_data_sel[i]) begin
                read_mux = read_mux | data_read_w[i];
            end
            if (rd_dir_sel[i]) begin
                read_mux = read_mux | dir_read_w[i];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= READ_NONE;
        end else if (bus.rd) begin
            rdata_reg <= read_mux;
        end else begin
            rdata_reg <= READ_NONE;
        end
    end

    assign rdata = rdata_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_write_latch_out: assert property (
        bus.wr && bus.addr == PORT_A_DATA_OFF |=> pins.out[PORT_A] == $past(bus.wdata)
    ) else $error("port A latch not updated by write");

    a_dir_drives_oe: assert property (
        bus.wr && bus.addr == PORT_A_DIR_OFF |=> pins.oe[PORT_A] == $past(bus.wdata)
    ) else $error("port A output enable does not follow direction write");

    a_input_write_quiet: assert property (
        bus.wr && bus.addr == PORT_E_DATA_OFF && dir_read_w[PORT_E] == 8'h00
        |=> pins.oe[PORT_E] == 8'h00
    ) else $error("write to input port drove its pins");

    a_read_latch_back: assert property (
        bus.rd && bus.addr == PORT_A_DATA_OFF && dir_read_w[PORT_A] == 8'hFF
        |=> rdata == pins.out[PORT_A]
    ) else $error("output port read did not return latch");

    a_read_pin_level: assert property (
        ($stable(pin_in[PORT_A]))[*3] ##0
        (bus.rd && bus.addr == PORT_A_DATA_OFF && dir_read_w[PORT_A] == 8'h00)
        |=> rdata == $past(pin_in[PORT_A])
    ) else $error("input port read did not return pin level");

    a_portc_upper_zero: assert property (
        bus.rd && bus.addr == PORT_C_DATA_OFF |=> rdata[7:5] == 3'h0
    ) else $error("port C data upper bits not zero");

    a_portc_dir_gap: assert property (
        bus.rd && bus.addr == PORT_C_DIR_OFF |=> rdata[6:5] == 2'h0
    ) else $error("port C direction bits 6..5 not zero");

    a_portd_top_zero: assert property (
        bus.rd && (bus.addr == PORT_D_DATA_OFF || bus.addr == PORT_D_DIR_OFF) |=> rdata[7] == 1'b0
    ) else $error("port D bit 7 not zero");

    a_portf_upper_zero: assert property (
        bus.rd && bus.addr == PORT_F_DATA_OFF |=> rdata[7:4] == 4'h0
    ) else $error("port F data upper bits not zero");

    a_busclk_toggles: assert property (
        busclk_en && $past(busclk_en)
        |-> pins.oe[PORT_C][BUSCLK_PIN] && pins.out[PORT_C][BUSCLK_PIN] != $past(pins.out[PORT_C][BUSCLK_PIN])
    ) else $error("bus clock not toggling on port C pin 2");

    a_claim_reads_zero: assert property (
        bus.rd && bus.addr == PORT_B_DATA_OFF && adc_claim_b[0] && !dir_read_w[PORT_B][0]
        |=> rdata[0] == 1'b0 && pins.oe[PORT_B][0] == 1'b0
    ) else $error("claimed port B pin read not zero");

    a_rdata_idle: assert property (
        !bus.rd |=> rdata == 8'h00
    ) else $error("read data not zero outside read cycle");
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench of the six-port parallel I/O bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin n_compared++; if ((act) !== (exp)) begin error_cnt++; \
    $display("unexpected at %0t: got %h want %h", $time, act, exp); end end
module tb_top;
    import sppio_pkg::*;

    // ------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    sppio_req_s bus = '0;
    logic [5:0][7:0] pin_in = '0;
    logic [7:0] adc_claim_b = 8'h00;
    logic [7:0] rdata;
    sppio_pins_s pins;
    int error_cnt = 0;
    int n_compared = 0;
    logic [7:0] lat;
    logic [7:0] pv;
    logic [7:0] dv;
    logic b0;

    always #2.5 clk = ~clk;

    sppio_bank i_dut (
        .clk(clk),
        .rst(rst),
        .bus(bus),
        .pin_in(pin_in),
        .adc_claim_b(adc_claim_b),
        .rdata(rdata),
        .pins(pins)
    );

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        `CHK(rdata, exp)
    endtask

    task automatic complete_run();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(5 * 5000);
        error_cnt++;
        complete_run();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK(pins.oe, 48'h0)
        for (int p = 0; p < 6; p++) begin
            lat = 8'hDA ^ 8'(p);
            pv = 8'hA5 ^ 8'(p);
            dv = (p == PORT_C) ? 8'h1F : 8'hFF;
            rd(DIR_OFF[p], 8'h00);
            @(posedge clk);
            pin_in[p] <= pv;
            wr(DATA_OFF[p], lat);
            `CHK(pins.oe[p], 8'h00)
            repeat (3) @(posedge clk);
            rd(DATA_OFF[p], pv & DATA_MASK[p]);
            wr(DIR_OFF[p], dv);
            `CHK(pins.oe[p], dv & DIR_MASK[p])
            `CHK(pins.out[p], lat & DATA_MASK[p])
            rd(DATA_OFF[p], lat & DATA_MASK[p]);
            rd(DIR_OFF[p], dv & DIR_MASK[p]);
        end
        // reset again: directions clear, latches survive
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK(pins.oe, 48'h0)
        for (int p = 0; p < 6; p++) begin
            rd(DIR_OFF[p], 8'h00);
            wr(DIR_OFF[p], (p == PORT_C) ? 8'h1F : 8'hFF);
            rd(DATA_OFF[p], (8'hDA ^ 8'(p)) & DATA_MASK[p]);
        end
        // bus clock image on port C bit two
        wr(PORT_C_DIR_OFF, 8'h80);
        @(posedge clk);
        #1;
        b0 = pins.out[PORT_C][BUSCLK_PIN];
        @(posedge clk);
        #1;
        `CHK(pins.out[PORT_C][BUSCLK_PIN], ~b0)
        `CHK(pins.oe[PORT_C][BUSCLK_PIN], 1'b1)
        rd(PORT_C_DIR_OFF, 8'h80);
        wr(PORT_C_DIR_OFF, 8'h00);
        `CHK(pins.oe[PORT_C], 8'h00)
        // converter claims on port B
        @(posedge clk);
        adc_claim_b <= 8'h0F;
        pin_in[PORT_B] <= 8'hFF;
        wr(PORT_B_DIR_OFF, 8'h00);
        repeat (3) @(posedge clk);
        rd(PORT_B_DATA_OFF, 8'hF0);
        wr(PORT_B_DIR_OFF, 8'hFF);
        `CHK(pins.oe[PORT_B], 8'hF0)
        rd(PORT_B_DATA_OFF, 8'hDB);
        // unmapped places and read data lifetime
        rd(4'hA, 8'h00);
        wr(4'hB, 8'hFF);
        rd(4'hB, 8'h00);
        rd(PORT_A_DIR_OFF, 8'hFF);
        @(posedge clk);
        #1;
        `CHK(rdata, 8'h00)
        complete_run();
    end
endmodule
`default_nettype wire
